// ---- hdl/cmb_pkg.sv ----
// Shared constants, register map and frame type for the CAN mailbox block
package cmb_pkg;
    // Register word addresses on the software port
    localparam logic [6:0] OFF_MAILBOX_ENABLE_DIRECTION_REG = 7'h00;
    localparam logic [6:0] OFF_TCR = 7'h01;
    localparam logic [6:0] OFF_RCR = 7'h02;
    localparam logic [6:0] OFF_MCR = 7'h03;
    localparam logic [6:0] OFF_GSR = 7'h04;
    localparam logic [6:0] OFF_IFR = 7'h05;
    localparam logic [6:0] OFF_LAM0H = 7'h06;
    localparam logic [6:0] OFF_LAM0L = 7'h07;
    localparam logic [6:0] OFF_MASK_HIGH_WORD = 7'h08;
    localparam logic [6:0] OFF_MASK_LOW_WORD = 7'h09;
    // Mailbox words: 7'h40 + box*8 + word
    localparam int MB_SEL_BIT = 6;
    localparam int W_IDL = 0;
    localparam int W_IDH = 1;
    localparam int W_CTRL = 2;
    localparam int W_DATA = 3;
    localparam int NUM_MB = 6;
    // Master control and status bit positions
    localparam int BIT_CCR = 12;
    localparam int BIT_CDR = 8;
    localparam int BIT_STM = 6;
    localparam int BIT_CCE = 4;
    // Identifier, mask and control field positions
    localparam int BIT_IDE = 15;
    localparam int BIT_AME = 14;
    localparam int BIT_AAM = 13;
    localparam int BIT_ACCEPT_BOTH_ID_TYPES = 15;
    localparam int BIT_RTR = 4;
    localparam int DLC_LSB = 0;
    // Per-mailbox bit bases: request n at 2+n, ack n at 8+n, pending n at 4+n
    localparam int TRS_LSB = 2;
    localparam int TA_LSB = 8;
    localparam int RMP_LSB = 4;
    localparam int MD_LSB = 4;
    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [28:0] NO_MASK = 29'h0000_0000;
    // Receive buffer depth
    localparam int FIFO_DEPTH = 8;

    // One frame as carried on the link
    typedef struct packed {
        logic extended_id_select;
        logic remote_request_bit;
        logic [28:0] id;
        logic [3:0] length_code;
        logic [63:0] data;
    } cmb_frame_t;
endpackage

// ---- hdl/cmb_link_if.sv ----
// Frame-level link between the mailbox controller and a far node
`timescale 1ns/1ps
interface cmb_link_if;
    logic tx_valid;                 // Controller offers a frame
    cmb_pkg::cmb_frame_t tx_frame;  // Frame offered by the controller
    logic tx_ack;                   // Far node acknowledges, one-cycle pulse
    logic rx_valid;                 // Far node offers a frame
    cmb_pkg::cmb_frame_t rx_frame;  // Frame offered by the far node
    logic rx_ready;                 // Controller buffer takes the frame

    modport dev (output tx_valid, output tx_frame, input tx_ack,
                 input rx_valid, input rx_frame, output rx_ready);
    modport node (input tx_valid, input tx_frame, output tx_ack,
                  output rx_valid, output rx_frame, input rx_ready);
endinterface

// ---- hdl/cmb_fifo.sv ----
// Receive frame buffer with valid/ready on both sides
`timescale 1ns/1ps
module cmb_fifo #(
    parameter int WIDTH = 99,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);

    // All buffer state in one record
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } cmb_fifo_st_t;

    cmb_fifo_st_t st_ff;
    cmb_fifo_st_t nxt_st;
    logic push;
    logic pop;

    // Flags come straight from the occupancy count
    assign in_ready = st_ff.cnt != (PW+1)'(DEPTH);
    assign out_valid = st_ff.cnt != '0;
    assign out_data = st_ff.mem[st_ff.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update; depth is a power of two so pointers wrap
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ---- hdl/cmb_controller.sv ----
// Mailbox controller: filtering, request/acknowledge and loopback test
`timescale 1ns/1ps
module cmb_controller (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Software register port, 16-bit words
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Link toward the far node
    cmb_link_if.dev link
);
    // Transmit engine states
    typedef enum logic {TX_IDLE, TX_WAIT} cmb_tx_t;

    // All controller state in one record
    typedef struct packed {
        logic [7:0] mailbox_enable_direction_reg;                   // Enables 5:0, directions 7:6
        logic [5:0] transmit_request_bit;                    // Transmit requests
        logic [5:0] ta;                     // Transmit acknowledges
        logic [3:0] receive_pending_bit;                    // Receive pending
        logic [5:0] ifr;                    // Mailbox flags
        logic config_change_request;                          // Configuration request
        logic contents_change_request;                          // Contents change request
        logic loopback_test_enable;                          // Loopback test enable
        logic cce;                          // Configuration granted
        logic [3:0][15:0] lam;              // Lower pair H/L, upper pair H/L
        logic [63:0][15:0] mb;              // Mailbox words
        logic [15:0] rdata;                 // Read data
        cmb_tx_t tx_st;                     // Transmit engine state
        logic [2:0] tx_box;                 // Box being sent
        logic tx_valid;                     // Frame offered on the link
        cmb_pkg::cmb_frame_t tx_frame;      // Frame being sent
    } cmb_ctl_st_t;

    cmb_ctl_st_t st_ff;
    cmb_ctl_st_t nxt_st;

    // Receive buffer wiring
    logic fifo_in_valid;
    cmb_pkg::cmb_frame_t fifo_in_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    cmb_pkg::cmb_frame_t fifo_out_data;
    logic fifo_out_ready;

    // Mailbox word index
    function automatic int unsigned wix(input int unsigned box, input int unsigned word);
        wix = box * 8 + word;
    endfunction

    // Acceptance test of one frame against one mailbox and its mask
    function automatic logic id_match(input logic [15:0] idh, input logic [15:0] idl,
                                      input logic [15:0] lamh, input logic [15:0] laml,
                                      input cmb_pkg::cmb_frame_t f);
        logic [28:0] m;
        logic both;
        m = idh[cmb_pkg::BIT_AME] ? {lamh[12:0], laml} : cmb_pkg::NO_MASK;
        both = idh[cmb_pkg::BIT_AME] & lamh[cmb_pkg::BIT_ACCEPT_BOTH_ID_TYPES];
        id_match = (((f.id ^ {idh[12:0], idl}) & ~m) == cmb_pkg::NO_MASK)
                   && (both || (f.extended_id_select == idh[cmb_pkg::BIT_IDE]));
    endfunction

    // Loopback feeds the buffer from the transmit engine, else the link does
    always_comb begin
        if (st_ff.loopback_test_enable) begin
            fifo_in_valid = st_ff.tx_st == TX_WAIT;
            fifo_in_data = st_ff.tx_frame;
        end else begin
            fifo_in_valid = link.rx_valid;
            fifo_in_data = link.rx_frame;
        end
    end

    // Mailbox updates stall while software edits contents or configures,
    // which backs the buffer up to the link rather than losing frames
    assign fifo_out_ready = !st_ff.contents_change_request && !st_ff.cce;

    cmb_fifo #(
        .WIDTH($bits(cmb_pkg::cmb_frame_t)),
        .DEPTH(cmb_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );

    // Next state: software access first, hardware events last so hardware updates win
    always_comb begin
        logic found;
        logic done;
        int unsigned b;
        found = 1'b0;
        done = 1'b0;
        b = 0;
        nxt_st = st_ff;

        // Software writes
        if (reg_wr) begin
            case (reg_addr)
                cmb_pkg::OFF_MAILBOX_ENABLE_DIRECTION_REG: nxt_st.mailbox_enable_direction_reg = reg_wdata[7:0];
                cmb_pkg::OFF_TCR: begin
                    nxt_st.transmit_request_bit[5:2] = st_ff.transmit_request_bit[5:2] | reg_wdata[7:4];
                    nxt_st.ta[5:2] = st_ff.ta[5:2] & ~reg_wdata[13:10];
                    nxt_st.ifr[5:2] = st_ff.ifr[5:2] & ~reg_wdata[13:10];
                end
                cmb_pkg::OFF_RCR: begin
                    nxt_st.receive_pending_bit = st_ff.receive_pending_bit & ~reg_wdata[7:4];
                    nxt_st.ifr[3:0] = st_ff.ifr[3:0] & ~reg_wdata[7:4];
                end
                cmb_pkg::OFF_MCR: begin
                    nxt_st.config_change_request = reg_wdata[cmb_pkg::BIT_CCR];
                    nxt_st.contents_change_request = reg_wdata[cmb_pkg::BIT_CDR];
                    nxt_st.loopback_test_enable = reg_wdata[cmb_pkg::BIT_STM];
                end
                cmb_pkg::OFF_LAM0H: nxt_st.lam[0] = reg_wdata;
                cmb_pkg::OFF_LAM0L: nxt_st.lam[1] = reg_wdata;
                cmb_pkg::OFF_MASK_HIGH_WORD: nxt_st.lam[2] = reg_wdata;
                cmb_pkg::OFF_MASK_LOW_WORD: nxt_st.lam[3] = reg_wdata;
                default: begin
                    // Software writes reach mailbox words only under a contents change request
                    if (reg_addr[cmb_pkg::MB_SEL_BIT] && st_ff.contents_change_request) begin
                        nxt_st.mb[reg_addr[5:0]] = reg_wdata;
                    end
                end
            endcase
        end

        // Software reads, answered one cycle later
        if (reg_rd) begin
            case (reg_addr)
                cmb_pkg::OFF_MAILBOX_ENABLE_DIRECTION_REG: nxt_st.rdata = {8'h00, st_ff.mailbox_enable_direction_reg};
                cmb_pkg::OFF_TCR: nxt_st.rdata = {2'b00, st_ff.ta[5:2], 2'b00,
                                                  st_ff.transmit_request_bit[5:2], 4'h0};
                cmb_pkg::OFF_RCR: nxt_st.rdata = {8'h00, st_ff.receive_pending_bit, 4'h0};
                cmb_pkg::OFF_MCR: nxt_st.rdata = {3'b000, st_ff.config_change_request, 3'b000, st_ff.contents_change_request,
                                                  1'b0, st_ff.loopback_test_enable, 6'h00};
                cmb_pkg::OFF_GSR: nxt_st.rdata = 16'(st_ff.cce) << cmb_pkg::BIT_CCE;
                cmb_pkg::OFF_IFR: nxt_st.rdata = {10'h000, st_ff.ifr};
                cmb_pkg::OFF_LAM0H: nxt_st.rdata = st_ff.lam[0];
                cmb_pkg::OFF_LAM0L: nxt_st.rdata = st_ff.lam[1];
                cmb_pkg::OFF_MASK_HIGH_WORD: nxt_st.rdata = st_ff.lam[2];
                cmb_pkg::OFF_MASK_LOW_WORD: nxt_st.rdata = st_ff.lam[3];
                default: begin
                    if (reg_addr[cmb_pkg::MB_SEL_BIT]) begin
                        nxt_st.rdata = st_ff.mb[reg_addr[5:0]];
                    end else begin
                        nxt_st.rdata = cmb_pkg::RST_WORD;
                    end
                end
            endcase
        end

        // Configuration is granted only once the transmitter is idle
        if (!st_ff.config_change_request) begin
            nxt_st.cce = 1'b0;
        end else if (st_ff.tx_st == TX_IDLE) begin
            nxt_st.cce = 1'b1;
        end

        // Transmit engine; the highest requesting enabled box wins
        case (st_ff.tx_st)
            TX_IDLE: begin
                if (!st_ff.config_change_request && !st_ff.cce) begin
                    for (int i = 2; i < cmb_pkg::NUM_MB; i++) begin
                        if (st_ff.transmit_request_bit[i] && st_ff.mailbox_enable_direction_reg[i]) begin
                            found = 1'b1;
                            b = i;
                        end
                    end
                end
                if (found) begin
                    nxt_st.tx_box = 3'(b);
                    nxt_st.tx_frame.extended_id_select = st_ff.mb[wix(b, cmb_pkg::W_IDH)][cmb_pkg::BIT_IDE];
                    nxt_st.tx_frame.id = {st_ff.mb[wix(b, cmb_pkg::W_IDH)][12:0],
                                          st_ff.mb[wix(b, cmb_pkg::W_IDL)]};
                    nxt_st.tx_frame.remote_request_bit = st_ff.mb[wix(b, cmb_pkg::W_CTRL)][cmb_pkg::BIT_RTR];
                    nxt_st.tx_frame.length_code = st_ff.mb[wix(b, cmb_pkg::W_CTRL)][3:0];
                    nxt_st.tx_frame.data = {st_ff.mb[wix(b, cmb_pkg::W_DATA)],
                                            st_ff.mb[wix(b, cmb_pkg::W_DATA + 1)],
                                            st_ff.mb[wix(b, cmb_pkg::W_DATA + 2)],
                                            st_ff.mb[wix(b, cmb_pkg::W_DATA + 3)]};
                    // In loopback nothing is offered on the link
                    nxt_st.tx_valid = !st_ff.loopback_test_enable;
                    nxt_st.tx_st = TX_WAIT;
                end
            end
            TX_WAIT: begin
                // Loopback acks itself once the buffer takes the frame
                done = st_ff.loopback_test_enable ? fifo_in_ready : link.tx_ack;
                if (done) begin
                    b = int'(st_ff.tx_box);
                    nxt_st.transmit_request_bit[b] = 1'b0;
                    // A remote request sent by a receive box gets no ack or flag
                    if (b >= 4 || !st_ff.mailbox_enable_direction_reg[cmb_pkg::MD_LSB + b]) begin
                        nxt_st.ta[b] = 1'b1;
                        nxt_st.ifr[b] = 1'b1;
                    end
                    nxt_st.tx_valid = 1'b0;
                    nxt_st.tx_st = TX_IDLE;
                end
            end
            default: nxt_st.tx_st = TX_IDLE;
        endcase

        // Receive store: the lowest enabled matching receive box takes it;
        // the auto-reply bit is never examined here, so no remote reply exists
        found = 1'b0;
        if (fifo_out_valid && fifo_out_ready) begin
            for (int i = 3; i >= 0; i--) begin
                if (st_ff.mailbox_enable_direction_reg[i] && (i < 2 || st_ff.mailbox_enable_direction_reg[cmb_pkg::MD_LSB + i])
                    && id_match(st_ff.mb[wix(i, cmb_pkg::W_IDH)],
                                st_ff.mb[wix(i, cmb_pkg::W_IDL)],
                                st_ff.lam[(i / 2) * 2],
                                st_ff.lam[(i / 2) * 2 + 1],
                                fifo_out_data)) begin
                    found = 1'b1;
                    b = i;
                end
            end
            if (found) begin
                nxt_st.mb[wix(b, cmb_pkg::W_CTRL)] = {11'h000, fifo_out_data.remote_request_bit,
                                                     fifo_out_data.length_code};
                for (int w = 0; w < 4; w++) begin
                    nxt_st.mb[wix(b, cmb_pkg::W_DATA + w)] =
                        fifo_out_data.data[63 - 16 * w -: 16];
                end
                nxt_st.receive_pending_bit[b] = 1'b1;
                nxt_st.ifr[b] = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.tx_st <= TX_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs; the far node is shut out entirely during loopback
    assign reg_rdata = st_ff.rdata;
    assign link.tx_valid = st_ff.tx_valid;
    assign link.tx_frame = st_ff.tx_frame;
    assign link.rx_ready = fifo_in_ready && !st_ff.loopback_test_enable;
endmodule

// ---- hdl/cmb_node.sv ----
// Far node: acknowledges controller frames and offers its own
`timescale 1ns/1ps
module cmb_node (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link toward the controller
    cmb_link_if.node link,
    // Frame to send
    input wire logic send_valid,
    input wire cmb_pkg::cmb_frame_t send_frame,
    output logic send_ready,
    // Frame received
    output logic recv_valid,
    output cmb_pkg::cmb_frame_t recv_frame
);
    // All node state in one record
    typedef struct packed {
        logic seen;                     // Current offered frame already acked
        logic tx_ack;                   // Acknowledge pulse
        logic rx_valid;                 // Frame offered to controller
        cmb_pkg::cmb_frame_t rx_frame;  // Frame offered to controller
        logic send_ready;               // Room for a new frame
        logic recv_valid;               // Received pulse
        cmb_pkg::cmb_frame_t recv_frame;// Received frame
    } cmb_node_st_t;

    cmb_node_st_t st_ff;
    cmb_node_st_t nxt_st;

    // Ack each offered frame once; the seen flag stops a second ack while
    // the controller is still dropping its valid
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tx_ack = 1'b0;
        nxt_st.recv_valid = 1'b0;
        if (!link.tx_valid) begin
            nxt_st.seen = 1'b0;
        end else if (!st_ff.seen) begin
            nxt_st.seen = 1'b1;
            nxt_st.tx_ack = 1'b1;
            nxt_st.recv_valid = 1'b1;
            nxt_st.recv_frame = link.tx_frame;
        end
        // Offer holds until the controller buffer takes it
        if (st_ff.rx_valid && link.rx_ready) begin
            nxt_st.rx_valid = 1'b0;
        end
        if (send_valid && st_ff.send_ready) begin
            nxt_st.rx_valid = 1'b1;
            nxt_st.rx_frame = send_frame;
        end
        nxt_st.send_ready = !nxt_st.rx_valid;
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs
    assign link.tx_ack = st_ff.tx_ack;
    assign link.rx_valid = st_ff.rx_valid;
    assign link.rx_frame = st_ff.rx_frame;
    assign send_ready = st_ff.send_ready;
    assign recv_valid = st_ff.recv_valid;
    assign recv_frame = st_ff.recv_frame;
endmodule

// ---- sim/cmb_asserts.sv ----
// Link-level checks between the mailbox controller and the far node
`timescale 1ns/1ps
module cmb_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Transmit direction
    input wire logic tx_valid,
    input wire cmb_pkg::cmb_frame_t tx_frame,
    input wire logic tx_ack,
    // Receive direction
    input wire logic rx_valid,
    input wire cmb_pkg::cmb_frame_t rx_frame,
    input wire logic rx_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // A fresh offer is acknowledged on the next edge
    property p_ack_next; $rose(tx_valid) |=> tx_ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    // Offer lasts exactly two cycles then drops
    property p_offer_len; $rose(tx_valid) |-> tx_valid [*2] ##1 !tx_valid; endproperty
    a_offer_len: assert property (p_offer_len) else $error("offer length");
    // Offer released right after the acknowledge
    property p_drop; tx_ack |=> !tx_valid; endproperty
    a_drop: assert property (p_drop) else $error("offer held");
    // Acknowledge is a single pulse
    property p_ack_pulse; tx_ack |=> !tx_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack wide");
    // Acknowledge only against a standing offer
    property p_ack_cause; tx_ack |-> tx_valid; endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    // Frame content steady while offered
    property p_tx_stable; tx_valid && $past(tx_valid) |-> $stable(tx_frame); endproperty
    a_tx_stable: assert property (p_tx_stable) else $error("tx frame moved");
    // At least two idle cycles between offers
    property p_gap; $fell(tx_valid) |=> !tx_valid; endproperty
    a_gap: assert property (p_gap) else $error("no gap");
    // Unaccepted receive frame holds still
    property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_frame); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx frame moved");
    // Main traffic seen
    c_tx: cover property (tx_valid && tx_ack);
    c_rx: cover property (rx_valid && rx_ready);
    c_stall: cover property (!rx_ready);
endmodule

// ---- sim/test_can_mailbox_filter_handshake.sv ----
// Self-checking bench for the mailbox controller facing the far node
`timescale 1ns/1ps
module test_can_mailbox_filter_handshake;
    // Clock, reset and register port
    logic core_clk = 0;
    logic rst = 1;
    logic [6:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [15:0] reg_rdata;
    // Far node user side
    logic send_valid = 0;
    cmb_pkg::cmb_frame_t send_frame = '0;
    logic send_ready;
    logic recv_valid;
    cmb_pkg::cmb_frame_t recv_frame;
    // Score keeping; saw_tx notes any offer on the wire
    int n_fail = 0;
    int checked = 0;
    logic saw_tx = 0;
    logic [63:0] pay = 64'h0123_4567_89ab_cdef;
    cmb_link_if cmb_link_if_i ();
    cmb_controller cmb_controller_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link(cmb_link_if_i));
    cmb_node cmb_node_i (.core_clk(core_clk), .rst(rst), .link(cmb_link_if_i),
        .send_valid(send_valid), .send_frame(send_frame), .send_ready(send_ready),
        .recv_valid(recv_valid), .recv_frame(recv_frame));
    cmb_asserts cmb_asserts_i (.core_clk(core_clk), .rst(rst),
        .tx_valid(cmb_link_if_i.tx_valid), .tx_frame(cmb_link_if_i.tx_frame),
        .tx_ack(cmb_link_if_i.tx_ack), .rx_valid(cmb_link_if_i.rx_valid),
        .rx_frame(cmb_link_if_i.rx_frame), .rx_ready(cmb_link_if_i.rx_ready));
    // 20 MHz clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // Offer monitor for the loopback and disabled-box checks
    always @(posedge core_clk) begin
        if (cmb_link_if_i.tx_valid === 1'b1) saw_tx <= 1'b1;
    end
    // Step n edges, then move 1 ns off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [98:0] exp, input logic [98:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // Mailbox word address
    function automatic logic [6:0] mb(input int b, input int w);
        return 7'(64 + b * 8 + w);
    endfunction
    // Write strobe for one cycle; idle cycle after keeps strobes apart
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        tick(1);
        reg_wr = 0;
        tick(1);
    endtask
    // Read and compare; data is registered at the taking edge
    task automatic rc(input logic [6:0] a, input logic [15:0] e);
        reg_addr = a;
        reg_rd = 1;
        tick(1);
        reg_rd = 0;
        chk(99'(e), 99'(reg_rdata));
        tick(1);
    endtask
    // Far node offers an extended data frame, held until taken
    task automatic send(input logic [28:0] id);
        int k;
        send_frame = {1'b1, 1'b0, id, 4'h8, 64'h1111_2222_3333_4444};
        send_valid = 1;
        for (k = 0; k < 20 && send_ready !== 1'b1; k++) tick(1);
        tick(1);
        send_valid = 0;
        tick(10);
    endtask
    task automatic t_tx;
        int k;
        wr(cmb_pkg::OFF_MAILBOX_ENABLE_DIRECTION_REG, 16'h0000);
        wr(cmb_pkg::OFF_MCR, 16'h0100);
        wr(mb(5, 0), 16'hffff);
        wr(mb(5, 1), 16'hffff);
        wr(mb(5, 2), 16'h0008);
        for (k = 0; k < 4; k++) wr(mb(5, 3 + k), pay[63 - 16 * k -: 16]);
        wr(cmb_pkg::OFF_MCR, 16'h0000);
        wr(cmb_pkg::OFF_TCR, 16'h0080);
        tick(5);
        chk(99'(0), 99'(saw_tx));
        wr(cmb_pkg::OFF_MAILBOX_ENABLE_DIRECTION_REG, 16'h0020);
        for (k = 0; k < 20 && recv_valid !== 1'b1; k++) tick(1);
        chk({1'b1, 1'b0, 29'h1fff_ffff, 4'h8, pay}, recv_frame);
        tick(2);
        rc(cmb_pkg::OFF_TCR, 16'h2000);
        rc(cmb_pkg::OFF_IFR, 16'h0020);
        wr(cmb_pkg::OFF_TCR, 16'h2000);
        rc(cmb_pkg::OFF_TCR, 16'h0000);
        rc(cmb_pkg::OFF_IFR, 16'h0000);
        $display("t_tx done");
    endtask
    task automatic t_rx;
        wr(cmb_pkg::OFF_MCR, 16'h0100);
        wr(cmb_pkg::OFF_LAM0H, 16'h8000);
        wr(cmb_pkg::OFF_LAM0L, 16'h00f0);
        wr(mb(0, 1), 16'hc000);
        wr(mb(0, 0), 16'h0000);
        wr(mb(1, 1), 16'h8000);
        wr(mb(1, 0), 16'h0000);
        wr(cmb_pkg::OFF_MCR, 16'h0000);
        wr(cmb_pkg::OFF_MAILBOX_ENABLE_DIRECTION_REG, 16'h0002);
        send(29'h0000_00f0);
        rc(cmb_pkg::OFF_RCR, 16'h0000);
        send(29'h0000_0000);
        rc(cmb_pkg::OFF_RCR, 16'h0020);
        rc(cmb_pkg::OFF_IFR, 16'h0002);
        wr(cmb_pkg::OFF_RCR, 16'h0020);
        wr(cmb_pkg::OFF_MAILBOX_ENABLE_DIRECTION_REG, 16'h0003);
        send(29'h0000_00f0);
        rc(cmb_pkg::OFF_RCR, 16'h0010);
        rc(mb(0, 3), 16'h1111);
        rc(mb(0, 6), 16'h4444);
        wr(cmb_pkg::OFF_RCR, 16'h0010);
        send(29'h0000_0f00);
        rc(cmb_pkg::OFF_RCR, 16'h0000);
        rc(cmb_pkg::OFF_IFR, 16'h0000);
        $display("t_rx done");
    endtask
    task automatic t_loop;
        wr(cmb_pkg::OFF_MCR, 16'h0100);
        wr(mb(2, 1), 16'hbfff);
        wr(mb(2, 0), 16'hffff);
        wr(cmb_pkg::OFF_MCR, 16'h0040);
        wr(cmb_pkg::OFF_MAILBOX_ENABLE_DIRECTION_REG, 16'h0064);
        saw_tx = 0;
        wr(cmb_pkg::OFF_TCR, 16'h0080);
        tick(10);
        chk(99'(0), 99'(saw_tx));
        rc(cmb_pkg::OFF_TCR, 16'h2000);
        rc(cmb_pkg::OFF_RCR, 16'h0040);
        rc(mb(2, 3), 16'h0123);
        wr(cmb_pkg::OFF_RCR, 16'h0040);
        wr(cmb_pkg::OFF_TCR, 16'h2000);
        rc(cmb_pkg::OFF_IFR, 16'h0000);
        wr(cmb_pkg::OFF_MCR, 16'h0000);
        $display("t_loop done");
    endtask
    task automatic t_cfg;
        wr(cmb_pkg::OFF_MCR, 16'h1000);
        tick(2);
        rc(cmb_pkg::OFF_GSR, 16'h0010);
        wr(cmb_pkg::OFF_MCR, 16'h0000);
        tick(2);
        rc(cmb_pkg::OFF_GSR, 16'h0000);
        wr(mb(4, 7), 16'ha5a5);
        rc(mb(4, 7), 16'h0000);
        wr(cmb_pkg::OFF_MCR, 16'h0100);
        wr(mb(4, 7), 16'ha5a5);
        rc(mb(4, 7), 16'ha5a5);
        wr(cmb_pkg::OFF_MCR, 16'h0000);
        rc(7'h7f, 16'h0000);
        $display("t_cfg done");
    endtask
    // Counts, verdict and end of run
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #1000000;
        n_fail++;
        test_done();
    end
    // Main sequence
    initial begin
        tick(5);
        rst = 0;
        t_tx();
        t_rx();
        t_loop();
        t_cfg();
        test_done();
    end
endmodule
